// ### design/sensor_cmd_decoder.sv
// command decoder for direct sensor register access over the hub message link
`timescale 1ns/1ps

module sensor_cmd_decoder (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic rx_start, // pulse: a new link write frame begins
  input wire logic rx_valid, // pulse: rx_data holds a received byte
  input wire logic [7:0] rx_data, // received command byte
  input wire logic tx_req, // pulse: link read wants the next byte
  output logic tx_valid, // pulse: tx_data holds the answered byte
  output logic [7:0] tx_data, // response byte
  output logic sens_req, // level: sensor access pending until ack
  output logic sens_we, // sensor access is a write
  output logic [2:0] sens_sel, // selected sensor
  output logic [7:0] sens_addr, // sensor register address
  output logic [7:0] sens_wdata, // sensor register write value
  input wire logic sens_ack, // pulse: sensor access done
  input wire logic [7:0] sens_rdata, // sensor read value, valid with ack
  output logic [4:0] sens_en // per-sensor enable, bit n for index n
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // index byte names an attached sensor
  function automatic logic idx_ok(input logic [7:0] idx);
    idx_ok = (idx <= sensor_cmd_pkg::IDX_ACCEL);
  endfunction

  // bytes in one register word of a sensor
  function automatic logic [7:0] word_bytes(input logic [2:0] sel);
    case (sel)
      3'h0: word_bytes = sensor_cmd_pkg::WORD_BYTES_OPTICAL;
      3'h1: word_bytes = sensor_cmd_pkg::WORD_BYTES_TEMP;
      3'h2: word_bytes = sensor_cmd_pkg::WORD_BYTES_BIOPOT;
      3'h3: word_bytes = sensor_cmd_pkg::WORD_BYTES_OXIM;
      default: word_bytes = sensor_cmd_pkg::WORD_BYTES_ACCEL;
    endcase
  endfunction

  // number of registers of a sensor
  function automatic logic [7:0] reg_count(input logic [2:0] sel);
    case (sel)
      3'h0: reg_count = sensor_cmd_pkg::REG_COUNT_OPTICAL;
      3'h1: reg_count = sensor_cmd_pkg::REG_COUNT_TEMP;
      3'h2: reg_count = sensor_cmd_pkg::REG_COUNT_BIOPOT;
      3'h3: reg_count = sensor_cmd_pkg::REG_COUNT_OXIM;
      default: reg_count = sensor_cmd_pkg::REG_COUNT_ACCEL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  sensor_cmd_pkg::state_t state_reg, state_next;
  logic [7:0] fam_reg, fam_next;
  logic [2:0] sel_reg, sel_next;
  logic [7:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic we_reg, we_next;
  logic req_reg, req_next;
  logic [7:0] rbuf_reg, rbuf_next;
  logic [8:0] pos_reg, pos_next;
  logic tx_valid_reg, tx_valid_next;
  logic [7:0] tx_data_reg, tx_data_next;
  logic [4:0] en_reg, en_next;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic of the decoder
  always_comb begin
    state_next = state_reg;
    fam_next = fam_reg;
    sel_next = sel_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    we_next = we_reg;
    req_next = req_reg;
    rbuf_next = rbuf_reg;
    pos_next = pos_reg;
    tx_valid_next = 1'b0;
    tx_data_next = tx_data_reg;
    en_next = en_reg;
    case (state_reg)
      sensor_cmd_pkg::ST_FAMILY: begin
        // first byte of a write frame is the family
        if (rx_valid) begin
          fam_next = rx_data;
          if (rx_data >= sensor_cmd_pkg::FAM_REG_WRITE &&
              rx_data <= sensor_cmd_pkg::FAM_SENS_EN) begin
            state_next = sensor_cmd_pkg::ST_INDEX;
          end else begin
            state_next = sensor_cmd_pkg::ST_IGNORE;
          end
        end
      end
      sensor_cmd_pkg::ST_INDEX: begin
        // second byte selects the sensor
        if (rx_valid) begin
          sel_next = rx_data[2:0];
          pos_next = sensor_cmd_pkg::POS_RST;
          if (!idx_ok(rx_data)) begin
            state_next = sensor_cmd_pkg::ST_IGNORE;
          end else if (fam_reg == sensor_cmd_pkg::FAM_ATTR ||
                       fam_reg == sensor_cmd_pkg::FAM_DUMP) begin
            state_next = sensor_cmd_pkg::ST_RESP;
          end else begin
            state_next = sensor_cmd_pkg::ST_ARG1;
          end
        end
      end
      sensor_cmd_pkg::ST_ARG1: begin
        // first write byte: address or control byte
        if (rx_valid) begin
          if (fam_reg == sensor_cmd_pkg::FAM_SENS_EN) begin
            if (rx_data == sensor_cmd_pkg::CTRL_DISABLE) begin
              en_next[sel_reg] = 1'b0;
            end else if (rx_data == sensor_cmd_pkg::CTRL_ENABLE) begin
              en_next[sel_reg] = 1'b1;
            end
            state_next = sensor_cmd_pkg::ST_IGNORE;
          end else if (fam_reg == sensor_cmd_pkg::FAM_REG_READ) begin
            addr_next = rx_data;
            we_next = 1'b0;
            req_next = 1'b1;
            state_next = sensor_cmd_pkg::ST_ACCESS;
          end else begin
            addr_next = rx_data;
            state_next = sensor_cmd_pkg::ST_ARG2;
          end
        end
      end
      sensor_cmd_pkg::ST_ARG2: begin
        // register value of a write, then the sensor write starts
        if (rx_valid) begin
          wdata_next = rx_data;
          we_next = 1'b1;
          req_next = 1'b1;
          state_next = sensor_cmd_pkg::ST_ACCESS;
        end
      end
      sensor_cmd_pkg::ST_ACCESS: begin
        // wait for the sensor; a read result is kept for the response
        if (sens_ack) begin
          req_next = 1'b0;
          if (we_reg) begin
            state_next = sensor_cmd_pkg::ST_IGNORE;
          end else begin
            rbuf_next = sens_rdata;
            pos_next = sensor_cmd_pkg::POS_RST;
            state_next = sensor_cmd_pkg::ST_RESP;
          end
        end
      end
      sensor_cmd_pkg::ST_RESP: begin
        // serve response bytes on link read requests
        if (tx_req) begin
          tx_valid_next = 1'b1;
          tx_data_next = sensor_cmd_pkg::FILL_BYTE;
          pos_next = pos_reg + 9'h001;
          if (fam_reg == sensor_cmd_pkg::FAM_REG_READ) begin
            if (pos_reg == 9'h000) begin
              tx_data_next = rbuf_reg;
            end
          end else if (fam_reg == sensor_cmd_pkg::FAM_ATTR) begin
            if (pos_reg == 9'h000) begin
              tx_data_next = word_bytes(sel_reg);
            end else if (pos_reg == 9'h001) begin
              tx_data_next = reg_count(sel_reg);
            end
          end else if (pos_reg[8:1] < reg_count(sel_reg)) begin
            if (!pos_reg[0]) begin
              tx_data_next = pos_reg[8:1];
            end else begin
              tx_valid_next = 1'b0;
              addr_next = pos_reg[8:1];
              we_next = 1'b0;
              req_next = 1'b1;
              state_next = sensor_cmd_pkg::ST_FETCH;
            end
          end
        end
      end
      sensor_cmd_pkg::ST_FETCH: begin
        // dump value byte answered straight from the sensor
        if (sens_ack) begin
          req_next = 1'b0;
          tx_valid_next = 1'b1;
          tx_data_next = sens_rdata;
          state_next = sensor_cmd_pkg::ST_RESP;
        end
      end
      default: begin
        // ignore remaining bytes of the frame
        state_next = sensor_cmd_pkg::ST_IGNORE;
      end
    endcase
    // reads with no response pending get a fill byte at once
    if (tx_req && state_reg != sensor_cmd_pkg::ST_RESP &&
        state_reg != sensor_cmd_pkg::ST_FETCH) begin
      tx_valid_next = 1'b1;
      tx_data_next = sensor_cmd_pkg::FILL_BYTE;
    end
    // a new write frame restarts decoding unless a sensor access is open
    if (rx_start && state_reg != sensor_cmd_pkg::ST_ACCESS &&
        state_reg != sensor_cmd_pkg::ST_FETCH) begin
      state_next = sensor_cmd_pkg::ST_FAMILY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoder registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= sensor_cmd_pkg::ST_FAMILY;
      fam_reg <= 8'h00;
      sel_reg <= 3'h0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      we_reg <= 1'b0;
      req_reg <= 1'b0;
      rbuf_reg <= 8'h00;
      pos_reg <= sensor_cmd_pkg::POS_RST;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= sensor_cmd_pkg::FILL_BYTE;
      en_reg <= sensor_cmd_pkg::SENS_EN_RST;
    end else begin
      state_reg <= state_next;
      fam_reg <= fam_next;
      sel_reg <= sel_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      we_reg <= we_next;
      req_reg <= req_next;
      rbuf_reg <= rbuf_next;
      pos_reg <= pos_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      en_reg <= en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign sens_req = req_reg;
  assign sens_we = we_reg;
  assign sens_sel = sel_reg;
  assign sens_addr = addr_reg;
  assign sens_wdata = wdata_reg;
  assign sens_en = en_reg;

endmodule

// ### shared/sensor_cmd_pkg.sv
// constants, codes and sensor attributes for the sensor register command decoder
package sensor_cmd_pkg;

  // command family bytes
  localparam logic [7:0] FAM_REG_WRITE = 8'h40;
  localparam logic [7:0] FAM_REG_READ = 8'h41;
  localparam logic [7:0] FAM_ATTR = 8'h42;
  localparam logic [7:0] FAM_DUMP = 8'h43;
  localparam logic [7:0] FAM_SENS_EN = 8'h44;

  // sensor selector codes carried in the index byte
  localparam logic [7:0] IDX_OPTICAL = 8'h00;
  localparam logic [7:0] IDX_TEMP = 8'h01;
  localparam logic [7:0] IDX_BIOPOT = 8'h02;
  localparam logic [7:0] IDX_OXIM = 8'h03;
  localparam logic [7:0] IDX_ACCEL = 8'h04;
  localparam int NUM_SENSORS = 5;

  // control byte of the enable family
  localparam logic [7:0] CTRL_DISABLE = 8'h00;
  localparam logic [7:0] CTRL_ENABLE = 8'h01;

  // byte answered when no response data is pending
  localparam logic [7:0] FILL_BYTE = 8'h00;

  // reset values
  localparam logic [4:0] SENS_EN_RST = 5'h00;
  localparam logic [8:0] POS_RST = 9'h000;

  // bytes per register word of each sensor (plain defaults, data path is one byte)
  localparam logic [7:0] WORD_BYTES_OPTICAL = 8'h01;
  localparam logic [7:0] WORD_BYTES_TEMP = 8'h01;
  localparam logic [7:0] WORD_BYTES_BIOPOT = 8'h01;
  localparam logic [7:0] WORD_BYTES_OXIM = 8'h01;
  localparam logic [7:0] WORD_BYTES_ACCEL = 8'h01;

  // number of registers of each sensor (plain defaults)
  localparam logic [7:0] REG_COUNT_OPTICAL = 8'h10;
  localparam logic [7:0] REG_COUNT_TEMP = 8'h04;
  localparam logic [7:0] REG_COUNT_BIOPOT = 8'h10;
  localparam logic [7:0] REG_COUNT_OXIM = 8'h10;
  localparam logic [7:0] REG_COUNT_ACCEL = 8'h08;

  // decoder state, gray coded along the usual path
  typedef enum logic [2:0] {
    ST_FAMILY = 3'h0,
    ST_INDEX  = 3'h1,
    ST_ARG1   = 3'h3,
    ST_ARG2   = 3'h2,
    ST_ACCESS = 3'h6,
    ST_RESP   = 3'h7,
    ST_FETCH  = 3'h5,
    ST_IGNORE = 3'h4
  } state_t;

endpackage

// ### bench/sensor_cmd_checker_assertions.sv
// port assertions for the sensor command decoder
`timescale 1ns/1ps
module sensor_cmd_checker (
  input wire logic mclk, rst, rx_start, rx_valid, tx_req, sens_ack, tx_valid, sens_req, sens_we,
  input wire logic [7:0] rx_data, sens_rdata, tx_data, sens_addr, sens_wdata,
  input wire logic [2:0] sens_sel,
  input wire logic [4:0] sens_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // sensor port handshake
  req_hold_a: assert property (sens_req && !sens_ack |=> sens_req &&
    $stable({sens_we, sens_sel, sens_addr, sens_wdata})) else $error("access changed early");
  req_drop_a: assert property (sens_req && sens_ack |=> !sens_req)
    else $error("access not closed");
  req_cause_a: assert property ($rose(sens_req) |-> $past(rx_valid) ||
    ($past(tx_req) && !sens_we)) else $error("access without cause");
  // response side, enables and reset
  txv_pulse_a: assert property (tx_valid |=> !tx_valid) else $error("answer too long");
  tx_cause_a: assert property (tx_valid |-> $past(tx_req) || $past(sens_ack))
    else $error("answer without request");
  dump_data_a: assert property (tx_valid && $past(sens_ack) |->
    tx_data == $past(sens_rdata)) else $error("dump value wrong");
  en_change_a: assert property ($changed(sens_en) |-> $past(rx_valid) &&
    $past(rx_data) <= 8'h01) else $error("enable changed without control byte");
  reset_clear_a: assert property (@(posedge mclk) disable iff (1'b0) rst |=> !tx_valid &&
    !sens_req && sens_en == 5'h00) else $error("reset not cleared");
  cover property (tx_valid && $past(sens_ack));
  cover property (sens_req && sens_we && sens_ack);
  cover property ($changed(sens_en));
endmodule
bind sensor_cmd_decoder sensor_cmd_checker i_chk (.mclk, .rst, .rx_start, .rx_valid, .tx_req,
  .sens_ack, .tx_valid, .sens_req, .sens_we, .rx_data, .sens_rdata, .tx_data, .sens_addr,
  .sens_wdata, .sens_sel, .sens_en);

// ### bench/sensor_model.sv
// behavioural model of the attached sensors
`timescale 1ns/1ps
module sensor_model (
  input wire logic mclk, rst, sens_req, sens_we,
  input wire logic [2:0] sens_sel,
  input wire logic [7:0] sens_addr, sens_wdata,
  input wire logic [3:0] lag, // answer delay
  output logic sens_ack, // access done
  output logic [7:0] sens_rdata // read value
);
  logic [7:0] mem [5][256];
  logic [3:0] cnt = 4'h0;
  initial begin
    sens_ack = 1'b0;
    sens_rdata = 8'h5A;
    for (int s = 0; s < 5; s++) for (int a = 0; a < 256; a++) mem[s][a] = 8'(s * 37 + a) ^ 8'hA5;
  end
  // wait lag cycles, then answer the access once
  always @(posedge mclk) begin
    sens_ack <= 1'b0;
    sens_rdata <= ~sens_rdata; // no steady data outside ack
    if (rst) cnt <= 4'h0;
    else if (sens_req && !sens_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lag) begin
        cnt <= 4'h0;
        sens_ack <= 1'b1;
        sens_rdata <= mem[sens_sel][sens_addr];
        if (sens_we) mem[sens_sel][sens_addr] <= sens_wdata;
      end
    end
  end
endmodule

// ### bench/sensor_cmd_decoder_bench.sv
// self-checking bench for the sensor command decoder
`timescale 1ns/1ps
module sensor_cmd_decoder_bench;
  logic mclk = 1'b0, rst = 1'b1, rx_start = 1'b0, rx_valid = 1'b0, tx_req = 1'b0;
  logic [7:0] rx_data = 8'h00, sens_addr, sens_wdata, sens_rdata, tx_data;
  logic tx_valid, sens_req, sens_we, sens_ack;
  logic [2:0] sens_sel;
  logic [4:0] sens_en, en_m = 5'h00;
  logic [3:0] lag = 4'h0;
  logic [31:0] rnd = 32'h2d69;
  logic [31:0] v = 32'h0; // random draw kept across send, which advances rnd for lag
  logic [7:0] mir [5][256];
  logic [7:0] regs [5] = '{8'h10, 8'h04, 8'h10, 8'h10, 8'h08};
  int fails = 0, comparisons = 0;
  sensor_cmd_decoder i_dut (.mclk, .rst, .rx_start, .rx_valid, .rx_data, .tx_req, .tx_valid,
    .tx_data, .sens_req, .sens_we, .sens_sel, .sens_addr, .sens_wdata, .sens_ack, .sens_rdata,
    .sens_en);
  sensor_model i_sen (.mclk, .rst, .sens_req, .sens_we, .sens_sel, .sens_addr, .sens_wdata,
    .lag, .sens_ack, .sens_rdata);
  initial forever #5 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string n, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one write frame, then wait for any sensor access to close
  task automatic send(input logic [7:0] q [$]);
    @(negedge mclk) rx_start = 1'b1;
    foreach (q[i]) begin
      @(negedge mclk) rx_start = 1'b0;
      rx_valid = 1'b1;
      rx_data = q[i];
      rnd = xs(rnd);
      lag = rnd[3:0];
    end
    @(negedge mclk) rx_valid = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      if (sens_req !== 1'b1) return;
    end
    fails++;
    end_sim();
  endtask
  // one link read byte
  task automatic fetch(input logic [7:0] exp);
    @(negedge mclk) tx_req = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk) tx_req = 1'b0;
      if (tx_valid === 1'b1) begin
        chk("tx_data", tx_data, exp);
        return;
      end
    end
    fails++;
    end_sim();
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    for (int s = 0; s < 5; s++) for (int a = 0; a < 256; a++) mir[s][a] = 8'(s * 37 + a) ^ 8'hA5;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    chk("sens_en", {3'h0, sens_en}, 8'h00);
    // write, read back and attributes of every sensor
    for (int s = 0; s < 5; s++) begin
      rnd = xs(rnd);
      v = rnd;
      send('{8'h40, 8'(s), v[7:0] & 8'h03, v[15:8]});
      mir[s][v[7:0] & 8'h03] = v[15:8];
      fetch(8'h00);
      send('{8'h41, 8'(s), v[7:0] & 8'h03});
      fetch(v[15:8]);
      send('{8'h41, 8'(s), v[23:16]});
      fetch(mir[s][v[23:16]]);
      send('{8'h42, 8'(s)});
      fetch(8'h01);
      fetch(regs[s]);
    end
    // dumps of the two shortest sensors, one read past the end
    for (int s = 1; s < 5; s += 3) begin
      send('{8'h43, 8'(s)});
      for (int a = 0; a < regs[s]; a++) begin
        fetch(8'(a));
        fetch(mir[s][a]);
      end
      fetch(8'h00);
    end
    // enables, bad control byte, bad index, bad family
    for (int s = 0; s < 5; s++) begin
      send('{8'h44, 8'(s), 8'h01});
      en_m[s] = 1'b1;
      chk("sens_en", {3'h0, sens_en}, {3'h0, en_m});
    end
    send('{8'h44, 8'h01, 8'h00});
    en_m[1] = 1'b0;
    send('{8'h44, 8'h02, 8'h02});
    send('{8'h44, 8'h05, 8'h00});
    send('{8'h45, 8'h00, 8'h00});
    chk("sens_en", {3'h0, sens_en}, {3'h0, en_m});
    fetch(8'h00);
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    chk("sens_en", {3'h0, sens_en}, 8'h00);
    fetch(8'h00);
    end_sim();
  end
endmodule
